// [verilog/tfcr_pkg.sv]
// Package: constants and carriers for the transmit credit reporting block
package tfcr_pkg;
  localparam int HDR_W        = 8;
  localparam int DATA_W       = 12;
  localparam int HDR_BYTES    = 20;
  localparam int DATA_BYTES   = 16;
  localparam int SEL_LATENCY  = 2;
  localparam int ERR_W        = 7;
  localparam int ERR_KIND_W   = 3;
  localparam int PEND_W       = 2;
  localparam int NUM_CLS      = 3;
  localparam int TYPE_W       = 6;

  localparam logic [1:0] CLS_POSTED    = 2'h0;
  localparam logic [1:0] CLS_NONPOSTED = 2'h1;
  localparam logic [1:0] CLS_COMPL     = 2'h2;

  // Type vector order: posted hdr/data, non-posted hdr/data, cpl hdr/data
  localparam int BIT_PH = 5;
  localparam int BIT_PD = 4;

  localparam logic [HDR_W-1:0]      HDR_RST   = 8'h00;
  localparam logic [DATA_W-1:0]     DATA_RST  = 12'h000;
  localparam logic [TYPE_W-1:0]     TYPE_RST  = 6'h00;
  localparam logic [ERR_W-1:0]      ERR_RST   = 7'h00;
  localparam logic [PEND_W-1:0]     PEND_MAX  = 2'h3;
  localparam logic [ERR_KIND_W-1:0] KIND_RST  = 3'h0;

  typedef struct packed {
    logic              valid;
    logic [1:0]        cls;
    logic              isData;
    logic              infinite;
    logic [DATA_W-1:0] value;
  } tfcr_limit_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] cls;
    logic       withData;
  } tfcr_icons_t;

  typedef struct packed {
    logic              valid;
    logic [1:0]        cls;
    logic [DATA_W-1:0] dataCredits;
  } tfcr_acons_t;
endpackage

// [verilog/tfcr_credit_report.sv]
// Transmit flow-control credit reporting and completion error logging
`timescale 1ns/1ps
module tfcr_credit_report
  import tfcr_pkg::*;
#(
  parameter bit CONS_SEL_EN = 1'b1
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  clkEn,
  input  wire logic                  linkUp,
  input  wire logic [1:0]            creditClassSelect,
  input  wire logic                  consumedSelect,
  input  wire tfcr_limit_t           limitUpdate,
  input  wire tfcr_icons_t           internalConsume,
  input  wire tfcr_acons_t           appConsume,
  input  wire logic [ERR_W-1:0]      complErrReport,
  input  wire logic                  errMsgReady,
  output logic [HDR_W-1:0]           headerCreditValue,
  output logic [DATA_W-1:0]          dataCreditValue,
  output logic [TYPE_W-1:0]          internalCreditConsumedPulse,
  output logic [TYPE_W-1:0]          creditUnlimitedFlags,
  output logic                       transmitStreamReady,
  output logic [ERR_W-1:0]           errStatus,
  output logic                       errMsgValid,
  output logic [ERR_KIND_W-1:0]      errMsgKind
);

  function automatic int hdrBit(input logic [1:0] cls);
    return BIT_PH - 2 * int'(cls);
  endfunction

  function automatic int dataBit(input logic [1:0] cls);
    return BIT_PD - 2 * int'(cls);
  endfunction

  logic [HDR_W-1:0]  limHdr_r  [NUM_CLS];
  logic [DATA_W-1:0] limData_r [NUM_CLS];
  logic [HDR_W-1:0]  conHdr_r  [NUM_CLS];
  logic [DATA_W-1:0] conData_r [NUM_CLS];
  logic [TYPE_W-1:0] unlimited_r;
  logic [1:0]        selStage_r;
  logic              consStage_r;
  logic [HDR_W-1:0]  hdrOut_r;
  logic [DATA_W-1:0] dataOut_r;
  logic [TYPE_W-1:0] pulse_r;
  logic [PEND_W-1:0] pend_r [ERR_W];
  logic [ERR_W-1:0]  status_r;
  logic              msgValid_r;
  logic [ERR_KIND_W-1:0] msgKind_r;
  logic              exhausted;
  logic              loadMsg;
  logic [ERR_W-1:0]  pendAny;
  logic [ERR_KIND_W-1:0] pickKind;

  // Limits and unlimited flags from the link's flow-control updates
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NUM_CLS; c++) begin
        limHdr_r[c]  <= HDR_RST;
        limData_r[c] <= DATA_RST;
      end
      unlimited_r <= TYPE_RST;
    end else if (clkEn && limitUpdate.valid &&
                 limitUpdate.cls != 2'h3) begin
      if (limitUpdate.isData) begin
        limData_r[limitUpdate.cls] <= limitUpdate.value;
        unlimited_r[dataBit(limitUpdate.cls)] <= limitUpdate.infinite;
      end else begin
        limHdr_r[limitUpdate.cls] <= limitUpdate.value[HDR_W-1:0];
        unlimited_r[hdrBit(limitUpdate.cls)] <= limitUpdate.infinite;
      end
    end
  end

  // Consumed counters wrap modulo their width, as credit arithmetic does
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NUM_CLS; c++) begin
        conHdr_r[c]  <= HDR_RST;
        conData_r[c] <= DATA_RST;
      end
    end else if (clkEn) begin
      for (int c = 0; c < NUM_CLS; c++) begin
        logic [HDR_W-1:0]  hInc;
        logic [DATA_W-1:0] dInc;
        hInc = HDR_RST;
        dInc = DATA_RST;
        if (internalConsume.valid && internalConsume.cls == 2'(c)) begin
          hInc = hInc + 8'h01;
          if (internalConsume.withData)
            dInc = dInc + 12'h001;
        end
        if (appConsume.valid && appConsume.cls == 2'(c)) begin
          hInc = hInc + 8'h01;
          dInc = dInc + appConsume.dataCredits;
        end
        conHdr_r[c]  <= conHdr_r[c] + hInc;
        conData_r[c] <= conData_r[c] + dInc;
      end
    end
  end

  // Internal pulses: one header bit, plus its data bit when data rides along
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulse_r <= TYPE_RST;
    end else if (clkEn) begin
      pulse_r <= TYPE_RST;
      if (internalConsume.valid && internalConsume.cls != 2'h3) begin
        pulse_r[hdrBit(internalConsume.cls)] <= 1'b1;
        if (internalConsume.withData)
          pulse_r[dataBit(internalConsume.cls)] <= 1'b1;
      end
    end
  end

  // Two-stage path: select captured, then the muxed value registered
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selStage_r  <= CLS_POSTED;
      consStage_r <= 1'b0;
      hdrOut_r    <= HDR_RST;
      dataOut_r   <= DATA_RST;
    end else if (clkEn) begin
      selStage_r  <= creditClassSelect;
      consStage_r <= CONS_SEL_EN && consumedSelect;
      if (!linkUp || selStage_r == 2'h3) begin
        // Code 11 is undefined; zero is shown rather than stale data
        hdrOut_r  <= HDR_RST;
        dataOut_r <= DATA_RST;
      end else if (consStage_r) begin
        hdrOut_r  <= conHdr_r[selStage_r];
        dataOut_r <= conData_r[selStage_r];
      end else begin
        hdrOut_r  <= limHdr_r[selStage_r];
        dataOut_r <= limData_r[selStage_r];
      end
    end
  end

  always_comb begin
    exhausted = 1'b0;
    for (int c = 0; c < NUM_CLS; c++) begin
      if (!unlimited_r[hdrBit(2'(c))] && limHdr_r[c] == conHdr_r[c])
        exhausted = 1'b1;
      if (!unlimited_r[dataBit(2'(c))] && limData_r[c] == conData_r[c])
        exhausted = 1'b1;
    end
  end

  // Error logging: per-kind pending count so back-to-back reports survive
  always_comb begin
    pickKind = KIND_RST;
    for (int k = ERR_W - 1; k >= 0; k--) begin
      pendAny[k] = pend_r[k] != 2'h0;
      if (pendAny[k])
        pickKind = 3'(k);
    end
  end

  assign loadMsg = (|pendAny) && (!msgValid_r || errMsgReady);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < ERR_W; k++)
        pend_r[k] <= 2'h0;
      status_r <= ERR_RST;
    end else if (clkEn) begin
      for (int k = 0; k < ERR_W; k++) begin
        logic dec;
        dec = loadMsg && pickKind == 3'(k);
        if (complErrReport[k]) begin
          status_r[k] <= 1'b1;
          // A report in the same cycle as a take keeps the count level
          if (!dec && pend_r[k] != PEND_MAX)
            pend_r[k] <= pend_r[k] + 2'h1;
        end else if (dec) begin
          pend_r[k] <= pend_r[k] - 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      msgValid_r <= 1'b0;
      msgKind_r  <= KIND_RST;
    end else if (clkEn) begin
      if (loadMsg) begin
        msgValid_r <= 1'b1;
        msgKind_r  <= pickKind;
      end else if (errMsgReady) begin
        msgValid_r <= 1'b0;
      end
    end
  end

  assign headerCreditValue           = hdrOut_r;
  assign dataCreditValue             = dataOut_r;
  assign internalCreditConsumedPulse = pulse_r;
  assign creditUnlimitedFlags        = unlimited_r;
  assign transmitStreamReady         = linkUp && !exhausted;
  assign errStatus                   = status_r;
  assign errMsgValid                 = msgValid_r;
  assign errMsgKind                  = msgKind_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence selHeldPosted;
    (clkEn && linkUp && creditClassSelect == CLS_POSTED &&
     !consumedSelect && !limitUpdate.valid) [*3];
  endsequence

  a_sel_latency: assert property (
    selHeldPosted |=> headerCreditValue == $past(limHdr_r[0]))
    else $error("credit output not following select after two clocks");

  a_pulse_cause: assert property (
    |internalCreditConsumedPulse && $past(clkEn) |->
      $past(internalConsume.valid))
    else $error("internal pulse without an internal consumption");

  a_no_app_pulse: assert property (
    clkEn && appConsume.valid && !internalConsume.valid |=>
      internalCreditConsumedPulse == TYPE_RST)
    else $error("internal pulse raised for application traffic");

  a_pulse_shape: assert property (
    $countones(internalCreditConsumedPulse & 6'h2A) <= 1 &&
    ((internalCreditConsumedPulse & 6'h15) << 1 &
     ~internalCreditConsumedPulse) == 6'h00)
    else $error("more than one header, or data without header");

  a_linkdown_zero: assert property (
    clkEn && !linkUp |=> headerCreditValue == HDR_RST &&
      dataCreditValue == DATA_RST)
    else $error("credit outputs nonzero before link up");

  a_unlim_flag: assert property (
    clkEn && limitUpdate.valid && !limitUpdate.isData &&
    limitUpdate.cls == CLS_COMPL |=>
      creditUnlimitedFlags[1] == $past(limitUpdate.infinite))
    else $error("unlimited flag not taken from update");

  a_ready_exhaust: assert property (
    !creditUnlimitedFlags[BIT_PH] && limHdr_r[0] == conHdr_r[0] |->
      !transmitStreamReady)
    else $error("stream ready with posted headers exhausted");

  a_err_logged: assert property (
    clkEn && complErrReport != ERR_RST |=>
      (errStatus & $past(complErrReport)) == $past(complErrReport))
    else $error("reported error not logged in status");

  a_err_msg: assert property (
    errMsgValid |-> errStatus[errMsgKind])
    else $error("error message without matching status bit");

  a_cons_sel: assert property (
    clkEn && !(CONS_SEL_EN && consumedSelect) |=> !consStage_r)
    else $error("consumed select honoured while option off");

endmodule

// [tb/tfcr_app_model.sv]
// Application-side partner: error reports and message acceptance
`timescale 1ns/1ps
module tfcr_app_model
  import tfcr_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  slowAck,
  input  wire logic                  errMsgValid,
  input  wire logic [ERR_KIND_W-1:0] errMsgKind,
  output logic      [ERR_W-1:0]      complErrReport,
  output logic                       errMsgReady
);
  int acceptCnt [ERR_W];
  initial begin
    complErrReport = '0;
    foreach (acceptCnt[i]) acceptCnt[i] = 0;
  end
  // One-cycle pulse per error occurrence
  task automatic report(input int k);
    @(negedge clk_sys);
    complErrReport[k] = 1'b1;
    @(negedge clk_sys);
    complErrReport = '0;
  endtask
  // Slow mode accepts every other cycle, so messages must hold
  always @(negedge clk_sys) begin
    errMsgReady <= slowAck ? ~errMsgReady : 1'b1;
  end
  always @(posedge clk_sys) begin
    if (errMsgValid && errMsgReady) begin
      acceptCnt[errMsgKind] <= acceptCnt[errMsgKind] + 1;
    end
  end
endmodule

// [tb/tfcr_credit_report_tb_top.sv]
// Self-checking bench for the transmit credit reporting block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tfcr_credit_report_tb_top
  import tfcr_pkg::*;
;
  logic                  clk_sys, resetn, clkEn, linkUp, consumedSelect;
  logic                  slowAck, errMsgValid, errMsgReady;
  logic                  transmitStreamReady;
  logic [1:0]            creditClassSelect;
  tfcr_limit_t           limitUpdate;
  tfcr_icons_t           internalConsume;
  tfcr_acons_t           appConsume;
  logic [ERR_W-1:0]      complErrReport, errStatus;
  logic [HDR_W-1:0]      headerCreditValue;
  logic [DATA_W-1:0]     dataCreditValue;
  logic [TYPE_W-1:0]     internalCreditConsumedPulse, creditUnlimitedFlags;
  logic [TYPE_W-1:0]     inf;
  logic [ERR_KIND_W-1:0] errMsgKind;
  int                    miscompares, total_checks, prevH, prevD;
  int                    limH [3], limD [3], conH [3], conD [3];

  tfcr_credit_report #(.CONS_SEL_EN(1'b1)) tfcr_credit_report_inst (
    .clk_sys, .resetn, .clkEn, .linkUp, .creditClassSelect,
    .consumedSelect, .limitUpdate, .internalConsume, .appConsume,
    .complErrReport, .errMsgReady, .headerCreditValue, .dataCreditValue,
    .internalCreditConsumedPulse, .creditUnlimitedFlags,
    .transmitStreamReady, .errStatus, .errMsgValid, .errMsgKind);
  tfcr_app_model tfcr_app_model_inst (.clk_sys, .slowAck, .errMsgValid,
    .errMsgKind, .complErrReport, .errMsgReady);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic expReady();
    expReady = linkUp;
    for (int c = 0; c < 3; c++) begin
      if (!inf[5-2*c] && limH[c] == conH[c]) expReady = 1'b0;
      if (!inf[4-2*c] && limD[c] == conD[c]) expReady = 1'b0;
    end
  endfunction

  task automatic setLimit(input int c, input int d, input bit f, input int v);
    limitUpdate = '{1'b1, c[1:0], d[0], f, v[11:0]};
    @(negedge clk_sys);
    inf[5-2*c-d] = f;
    if (d == 1) limD[c] = v % 4096;
    else limH[c] = v % 256;
  endtask

  task automatic consume(input int ic, input bit iw, input bit iv,
                         input int ac, input int ad);
    logic [TYPE_W-1:0] ep;
    ep = iv ? ((6'h20 | (iw ? 6'h10 : 6'h00)) >> (2 * ic)) : 6'h00;
    internalConsume = '{iv, ic[1:0], iw};
    appConsume = '{1'b1, ac[1:0], ad[11:0]};
    @(negedge clk_sys);
    internalConsume = '0;
    appConsume = '0;
    // Totals are internal plus application use
    if (iv) conH[ic] = (conH[ic] + 1) % 256;
    if (iv) conD[ic] = (conD[ic] + iw) % 4096;
    conH[ac] = (conH[ac] + 1) % 256;
    conD[ac] = (conD[ac] + ad) % 4096;
    `CHK(internalCreditConsumedPulse, ep)
    `CHK(transmitStreamReady, expReady())
    @(negedge clk_sys);
    `CHK(internalCreditConsumedPulse, 6'h00)
  endtask

  task automatic readout(input int c, input bit cs);
    int eh;
    int ed;
    eh = cs ? conH[c] : limH[c];
    ed = cs ? conD[c] : limD[c];
    creditClassSelect = c[1:0];
    consumedSelect = cs;
    @(negedge clk_sys);
    `CHK(headerCreditValue, prevH[7:0])
    `CHK(dataCreditValue, prevD[11:0])
    @(negedge clk_sys);
    `CHK(headerCreditValue, eh[7:0])
    `CHK(dataCreditValue, ed[11:0])
    prevH = eh;
    prevD = ed;
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under two thousand cycles
  initial begin
    #20000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(32'h1031B859));
    {resetn, linkUp, consumedSelect, slowAck, creditClassSelect} = '0;
    clkEn = 1'b1;
    limitUpdate = '0;
    internalConsume = '0;
    appConsume = '0;
    inf = '0;
    foreach (limH[i]) begin
      {limH[i], limD[i], conH[i], conD[i]} = '0;
    end
    repeat (2) @(negedge clk_sys);
    `CHK(internalCreditConsumedPulse, 6'h00)
    `CHK(headerCreditValue, 8'h00)
    `CHK(errStatus, 7'h00)
    resetn = 1'b1;
    // Completion types unlimited; posted header kept small to exhaust
    for (int t = 0; t < 6; t++) begin
      setLimit(t / 2, t % 2, t >= 4, t == 0 ? 32 : $urandom_range(4095, 300));
    end
    // Cleared once after the burst so no update is driven twice per step
    limitUpdate = '0;
    `CHK(headerCreditValue, 8'h00)
    `CHK(transmitStreamReady, 1'b0)
    linkUp = 1'b1;
    repeat (3) @(negedge clk_sys);
    prevH = limH[0];
    prevD = limD[0];
    `CHK(headerCreditValue, prevH[7:0])
    `CHK(creditUnlimitedFlags, inf)
    $display("Test reset and limits done");
    for (int i = 0; i < 6; i++) begin
      consume(i / 2, i % 2, 1'b1, $urandom_range(2), $urandom_range(15));
    end
    while (conH[0] != limH[0]) consume(0, 1'b0, 1'b0, 0, 0);
    `CHK(transmitStreamReady, 1'b0)
    $display("Test consumption done");
    for (int i = 0; i < 9; i++) begin
      readout(i < 6 ? i % 3 : $urandom_range(2),
              i < 6 ? i / 3 : $urandom_range(1));
    end
    // Frozen clock enable: a select change must not reach the outputs
    clkEn = 1'b0;
    consumedSelect = ~consumedSelect;
    repeat (3) @(negedge clk_sys);
    `CHK(headerCreditValue, prevH[7:0])
    `CHK(dataCreditValue, prevD[11:0])
    clkEn = 1'b1;
    $display("Test readout done");
    slowAck = 1'b1;
    tfcr_app_model_inst.report(2);
    `CHK(errStatus, 7'h04)
    // Application sends the abort completion itself; no internal pulse
    consume(0, 1'b0, 1'b0, 2, 1);
    tfcr_app_model_inst.report(2);
    tfcr_app_model_inst.report(0);
    repeat (20) @(negedge clk_sys);
    `CHK(tfcr_app_model_inst.acceptCnt[2], 2)
    `CHK(tfcr_app_model_inst.acceptCnt[0], 1)
    `CHK(errStatus, 7'h05)
    $display("Test error logging done");
    results();
  end
endmodule
